// ===== verilog/vfm_pkg.sv
// Register map, operation codes and shared types of the vector FP misc datapath
package vfm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_OPA = 8'h00;
    localparam logic [7:0] OFS_OPB = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_LEN = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_RES_LO = 8'h18;
    localparam logic [7:0] OFS_RES_HI = 8'h1c;
    localparam logic [7:0] OFS_CMASK = 8'h20;
    localparam logic [7:0] OFS_STAT = 8'h24;
    // Field positions
    localparam int CTRL_RM_LSB = 0;
    localparam int CTRL_MEN_BIT = 3;
    localparam int CTRL_SCAL_BIT = 4;
    localparam int CTRL_SRC2_LSB = 5;
    localparam int LEN_VL_LSB = 0;
    localparam int LEN_START_LSB = 8;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_IDX_LSB = 8;
    localparam int STAT_FLG_LSB = 0;
    localparam int STAT_DONE_BIT = 8;
    localparam int STAT_WROTE_BIT = 9;
    localparam int STAT_ILL_BIT = 10;
    localparam int FLG_NV = 4;
    localparam int FLG_NX = 0;
    // Rounding modes
    localparam logic [2:0] RM_RNE = 3'h0;
    localparam logic [2:0] RM_RTZ = 3'h1;
    localparam logic [2:0] RM_RDN = 3'h2;
    localparam logic [2:0] RM_RUP = 3'h3;
    localparam logic [2:0] RM_RMM = 3'h4;
    // Canonical NaNs
    localparam logic [31:0] CNAN32 = 32'h7fc00000;
    localparam logic [63:0] CNAN64 = 64'h7ff8000000000000;

    typedef enum logic [4:0] {
        OP_MIN, OP_MAX, OP_SGNJ, OP_SGNJN, OP_SGNJX,
        OP_FEQ, OP_FNE, OP_FLT, OP_FLE, OP_FGT, OP_FGE,
        OP_CLASS, OP_MERGE,
        OP_CVT_XU, OP_CVT_X, OP_CVT_RTZ_XU, OP_CVT_RTZ_X, OP_CVT_F_XU, OP_CVT_F_X,
        OP_WCVT_XU, OP_WCVT_X, OP_WCVT_RTZ_XU, OP_WCVT_RTZ_X, OP_WCVT_F_XU,
        OP_WCVT_F_X, OP_WCVT_F_F
    } vfm_op_t;

    typedef struct packed {
        logic [31:0] a;
        logic to_int;
        logic from_int;
        logic sgn;
        logic wide;
        logic [2:0] rm;
    } vfm_cvt_req_t;

    typedef struct packed {
        logic [63:0] res;
        logic [4:0] flags;
    } vfm_cvt_rsp_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [2:0] round_mode;
        logic mask_enable_bit;
        logic scalar_op;
        logic [4:0] second_vec_source_field;
        logic [5:0] vector_length_setting;
        logic [5:0] start_index;
        logic [31:0] src_mask;
        vfm_op_t op;
        logic [4:0] idx;
        logic go;
        logic [63:0] res;
        logic [31:0] cmp_mask;
        logic [4:0] flags;
        logic done;
        logic wrote;
        logic ill;
    } vfm_st_t;

    localparam vfm_st_t VFM_ST_RST = '0;
endpackage

// ===== verilog/vfm_cvt.sv
// Float/integer and float/float conversion unit, single and double width
`timescale 1ns/100ps
`default_nettype none
module vfm_cvt (
    // Conversion request
    input wire vfm_pkg::vfm_cvt_req_t req,
    // Result and flags
    output var vfm_pkg::vfm_cvt_rsp_t rsp
);
    import vfm_pkg::*;

    function automatic logic rnd_inc(input logic [2:0] rm, input logic neg,
                                     input logic lsb, input logic rb, input logic st);
        case (rm)
            RM_RNE: rnd_inc = rb & (st | lsb);
            RM_RDN: rnd_inc = neg & (rb | st);
            RM_RUP: rnd_inc = !neg & (rb | st);
            RM_RMM: rnd_inc = rb;
            default: rnd_inc = 1'b0;
        endcase
    endfunction

    function automatic logic [5:0] lzc32(input logic [31:0] v);
        lzc32 = 6'h20;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                lzc32 = 6'(31 - i);
            end
        end
    endfunction

    logic sgn_in, nan, snan, inf, zero, big, rb, st, nv, nx, neg_i;
    logic [7:0] ex, eu;
    logic [87:0] fx;
    logic [64:0] mag, umax, smax;
    logic [63:0] ires;
    logic [31:0] u, nrm;
    logic [30:0] sum;
    logic [5:0] lz, lzs;

    always_comb begin
        sgn_in = req.a[31];
        ex = req.a[30:23];
        nan = (ex == 8'hff) && (req.a[22:0] != 23'h0);
        snan = nan && !req.a[22];
        inf = (ex == 8'hff) && !nan;
        zero = req.a[30:0] == 31'h0;
        eu = (ex == 8'h00) ? 8'h01 : ex;
        // Fixed point: 64 integer bits, 24 fraction bits
        fx = {40'h0, ex != 8'h00, req.a[22:0], 24'h0};
        big = 1'b0;
        if (eu >= 8'h96) begin
            big = eu > 8'hbe;
            fx = big ? fx : fx << (eu - 8'h96);
        end else if (eu < 8'h7e) begin
            // Below one half: only the sticky bit survives
            fx = {87'h0, !zero};
        end else begin
            fx = fx >> (8'h96 - eu);
        end
        rb = fx[23];
        st = |fx[22:0];
        mag = {1'b0, fx[87:24]} + 65'(rnd_inc(req.rm, sgn_in, fx[24], rb, st));
        umax = req.wide ? {1'b0, {64{1'b1}}} : 65'h0ffffffff;
        smax = req.wide ? 65'h07fffffffffffffff : 65'h00000007fffffff;
        nv = 1'b0;
        nx = 1'b0;
        // Saturate and flag exactly as the scalar conversions do
        if (nan || (inf && !sgn_in)) begin
            nv = 1'b1;
            ires = req.sgn ? smax[63:0] : umax[63:0];
        end else if (inf) begin
            nv = 1'b1;
            ires = req.sgn ? ~smax[63:0] : 64'h0;
        end else if (!req.sgn && sgn_in && (big || mag != 65'h0)) begin
            nv = 1'b1;
            ires = 64'h0;
        end else if (!req.sgn && (big || mag > umax)) begin
            nv = 1'b1;
            ires = umax[63:0];
        end else if (req.sgn && !sgn_in && (big || mag > smax)) begin
            nv = 1'b1;
            ires = smax[63:0];
        end else if (req.sgn && (big || mag > smax + 65'h1)) begin
            nv = 1'b1;
            ires = ~smax[63:0];
        end else begin
            ires = sgn_in ? 64'(-mag) : mag[63:0];
            nx = rb | st;
        end
        // Integer to float
        neg_i = req.sgn && req.a[31];
        u = neg_i ? -req.a : req.a;
        lz = lzc32(u);
        nrm = u << lz;
        sum = {8'h9e - 8'(lz), nrm[30:8]} + 31'(rnd_inc(req.rm, neg_i, nrm[8], nrm[7], |nrm[6:0]));
        lzs = lzc32({9'h0, req.a[22:0]});
        rsp.flags = 5'h0;
        if (req.to_int) begin
            rsp.res = req.wide ? ires : {32'h0, ires[31:0]};
            rsp.flags[FLG_NV] = nv;
            rsp.flags[FLG_NX] = nx;
        end else if (req.from_int) begin
            if (u == 32'h0) begin
                rsp.res = 64'h0;
            end else if (req.wide) begin
                // Always exact at double width
                rsp.res = {neg_i, 11'h41e - 11'(lz), nrm[30:0], 21'h0};
            end else begin
                rsp.res = {32'h0, neg_i, sum};
                rsp.flags[FLG_NX] = |nrm[7:0];
            end
        end else if (nan) begin
            rsp.res = CNAN64;
            rsp.flags[FLG_NV] = snan;
        end else if (inf || zero) begin
            rsp.res = {sgn_in, inf ? 11'h7ff : 11'h000, 52'h0};
        end else if (ex == 8'h00) begin
            rsp.res = {sgn_in, 11'h389 - 11'(lzs), 52'({29'h0, req.a[22:0]} << (6'd21 + lzs))};
        end else begin
            rsp.res = {sgn_in, 11'(ex) + 11'h380, req.a[22:0], 29'h0};
        end
    end
endmodule
`default_nettype wire

// ===== verilog/vfm_top.sv
// Vector FP element datapath: min/max, sign injection, compares, classify, merge, converts
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Min and max return minimumNumber or maximumNumber of the two operands.
// - Sign injection keeps all non-sign bits of the first vector operand.
// - Compares write one bit per element into a single mask register.
// - Compare destination may be the same register as the source mask; here it is always the separate compare mask register.
// - Compares always treat tail elements as tail agnostic.
// - Equal and not-equal flag invalid only on signaling NaN inputs.
// - Ordered compares flag invalid on any NaN input.
// - With a NaN operand, not-equal gives one, all other compares zero.
// - Greater compares exist only with a scalar second operand.
// - Classify puts the ten-bit class in low bits, upper bits zero.
// - Classify needs element width of sixteen bits or more.
// - Merge writes every body element from start index to length, ignoring mask.
// - Merge takes vector element where mask is zero, else the scalar.
// - Move copies the scalar into every active element, unmasked.
// - Single-width converts between float and signed or unsigned integers.
// - Converts use the dynamic rounding mode; truncating forms round to zero.
// - Exceptional converts flag and saturate exactly like scalar converts.
// - Widening converts yield double-width integer or float elements.
module vfm_top #(
    parameter int element_width = 32,
    parameter int num_elem = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import vfm_pkg::*;

    // Only binary32 elements are built
    if (element_width != 32) begin : g_bad_width
        $error("vfm_top: element_width must be 32");
    end
    // Class mask needs at least sixteen element bits
    if (element_width < 16) begin : g_no_class
        $error("vfm_top: element_width below 16 cannot classify");
    end
    if (num_elem < 1 || num_elem > 32) begin : g_bad_count
        $error("vfm_top: num_elem must lie in 1..32");
    end

    vfm_st_t st;
    vfm_st_t next_st;
    vfm_cvt_req_t cvt_req;
    vfm_cvt_rsp_t cvt_rsp;

    function automatic logic is_nan(input logic [31:0] x);
        is_nan = (x[30:23] == 8'hff) && (x[22:0] != 23'h0);
    endfunction

    function automatic logic is_snan(input logic [31:0] x);
        is_snan = is_nan(x) && !x[22];
    endfunction

    // Ordered less-than for non-NaN values; zeros of either sign are equal
    function automatic logic f_lt(input logic [31:0] x, input logic [31:0] y);
        logic both_zero;
        both_zero = (x[30:0] == 31'h0) && (y[30:0] == 31'h0);
        if (both_zero) begin
            f_lt = 1'b0;
        end else if (x[31] != y[31]) begin
            f_lt = x[31];
        end else if (x[31]) begin
            f_lt = x[30:0] > y[30:0];
        end else begin
            f_lt = x[30:0] < y[30:0];
        end
    endfunction

    function automatic logic f_eq(input logic [31:0] x, input logic [31:0] y);
        f_eq = (x == y) || ((x[30:0] == 31'h0) && (y[30:0] == 31'h0));
    endfunction

    function automatic logic [9:0] f_class(input logic [31:0] x);
        logic s;
        logic [7:0] e;
        logic [22:0] f;
        s = x[31];
        e = x[30:23];
        f = x[22:0];
        f_class = 10'h000;
        if (e == 8'hff && f != 23'h0) begin
            f_class[f[22] ? 9 : 8] = 1'b1;
        end else if (e == 8'hff) begin
            f_class[s ? 0 : 7] = 1'b1;
        end else if (e == 8'h00 && f == 23'h0) begin
            f_class[s ? 3 : 4] = 1'b1;
        end else if (e == 8'h00) begin
            f_class[s ? 2 : 5] = 1'b1;
        end else begin
            f_class[s ? 1 : 6] = 1'b1;
        end
    endfunction

    // Conversion request follows the held operation
    always_comb begin
        cvt_req.a = st.opa;
        cvt_req.to_int = st.op inside {[OP_CVT_XU : OP_CVT_RTZ_X],
                                       [OP_WCVT_XU : OP_WCVT_RTZ_X]};
        cvt_req.from_int = st.op inside {OP_CVT_F_XU, OP_CVT_F_X, OP_WCVT_F_XU, OP_WCVT_F_X};
        cvt_req.sgn = st.op inside {OP_CVT_X, OP_CVT_RTZ_X, OP_CVT_F_X,
                                    OP_WCVT_X, OP_WCVT_RTZ_X, OP_WCVT_F_X};
        cvt_req.wide = st.op inside {[OP_WCVT_XU : OP_WCVT_F_F]};
        // Truncating forms ignore the dynamic mode
        if (st.op inside {OP_CVT_RTZ_XU, OP_CVT_RTZ_X, OP_WCVT_RTZ_XU, OP_WCVT_RTZ_X}) begin
            cvt_req.rm = RM_RTZ;
        end else begin
            cvt_req.rm = st.round_mode;
        end
    end

    // Converter is combinational so its result is ready in the execute cycle
    vfm_cvt u_cvt (
        .req(cvt_req),
        .rsp(cvt_rsp)
    );

    always_comb begin
        logic any_nan, any_snan, lt_ab, lt_ba, eq_ab, cmp, body, active, bad;
        logic [31:0] a, b, r32;
        logic [4:0] fl;
        next_st = st;
        next_st.pready = 1'b0;
        next_st.go = 1'b0;
        // Read data shows only while ready stands
        next_st.prdata = 32'h0;
        a = st.opa;
        b = st.opb;
        any_nan = is_nan(a) || is_nan(b);
        any_snan = is_snan(a) || is_snan(b);
        lt_ab = f_lt(a, b);
        lt_ba = f_lt(b, a);
        eq_ab = f_eq(a, b);
        cmp = 1'b0;
        r32 = 32'h0;
        fl = 5'h0;
        body = ({1'b0, st.idx} >= st.start_index) &&
               ({1'b0, st.idx} < st.vector_length_setting);
        // Unmasked ops treat every body element as active
        active = body && (st.mask_enable_bit || st.src_mask[st.idx]);
        // Unknown ops and out-of-range indices are refused
        bad = (st.op > OP_WCVT_F_F) || ({1'b0, st.idx} >= 6'(num_elem));

        // Element operation
        case (st.op)
            OP_MIN, OP_MAX: begin
                // Negative zero orders below positive zero
                fl[FLG_NV] = any_snan;
                if (is_nan(a) && is_nan(b)) begin
                    r32 = CNAN32;
                end else if (is_nan(a)) begin
                    r32 = b;
                end else if (is_nan(b)) begin
                    r32 = a;
                end else if ((st.op == OP_MIN) == (lt_ab || (a[31] && !b[31]))) begin
                    r32 = a;
                end else begin
                    r32 = b;
                end
            end
            OP_SGNJ: begin
                r32 = {b[31], a[30:0]};
            end
            OP_SGNJN: begin
                r32 = {!b[31], a[30:0]};
            end
            OP_SGNJX: begin
                r32 = {a[31] ^ b[31], a[30:0]};
            end
            OP_FEQ: begin
                cmp = !any_nan && eq_ab;
                fl[FLG_NV] = any_snan;
            end
            OP_FNE: begin
                cmp = any_nan || !eq_ab;
                fl[FLG_NV] = any_snan;
            end
            OP_FLT: begin
                cmp = !any_nan && lt_ab;
                fl[FLG_NV] = any_nan;
            end
            OP_FLE: begin
                cmp = !any_nan && (lt_ab || eq_ab);
                fl[FLG_NV] = any_nan;
            end
            OP_FGT: begin
                cmp = !any_nan && lt_ba;
                fl[FLG_NV] = any_nan;
                bad = bad || !st.scalar_op;
            end
            OP_FGE: begin
                cmp = !any_nan && (lt_ba || eq_ab);
                fl[FLG_NV] = any_nan;
                bad = bad || !st.scalar_op;
            end
            OP_CLASS: begin
                r32 = {22'h0, f_class(a)};
            end
            OP_MERGE: begin
                // Move shares this code; its source field must be zero
                bad = bad || (st.mask_enable_bit && st.second_vec_source_field != 5'h0);
                r32 = (st.mask_enable_bit || st.src_mask[st.idx]) ? b : a;
            end
            default: begin
                fl = cvt_rsp.flags;
                // Reserved rounding modes cannot be served
                bad = bad || (st.round_mode > RM_RMM);
            end
        endcase

        // APB access phase; answer one cycle later
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            // Error flag is refreshed only here and holds between transfers
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0;
            if (pwrite) begin
                case (paddr)
                    OFS_OPA: next_st.opa = pwdata;
                    OFS_OPB: next_st.opb = pwdata;
                    OFS_CTRL: begin
                        next_st.round_mode = pwdata[CTRL_RM_LSB +: 3];
                        next_st.mask_enable_bit = pwdata[CTRL_MEN_BIT];
                        next_st.scalar_op = pwdata[CTRL_SCAL_BIT];
                        next_st.second_vec_source_field = pwdata[CTRL_SRC2_LSB +: 5];
                    end
                    OFS_LEN: begin
                        next_st.vector_length_setting = pwdata[LEN_VL_LSB +: 6];
                        next_st.start_index = pwdata[LEN_START_LSB +: 6];
                    end
                    OFS_MASK: next_st.src_mask = pwdata;
                    OFS_CMD: begin
                        next_st.op = vfm_op_t'(pwdata[CMD_OP_LSB +: 5]);
                        next_st.idx = pwdata[CMD_IDX_LSB +: 5];
                        next_st.go = 1'b1;
                        next_st.done = 1'b0;
                    end
                    OFS_CMASK: next_st.cmp_mask = pwdata;
                    OFS_STAT: begin
                        // Write one to clear
                        next_st.flags = st.flags & ~pwdata[STAT_FLG_LSB +: 5];
                        next_st.done = st.done & ~pwdata[STAT_DONE_BIT];
                        next_st.wrote = st.wrote & ~pwdata[STAT_WROTE_BIT];
                        next_st.ill = st.ill & ~pwdata[STAT_ILL_BIT];
                    end
                    OFS_RES_LO, OFS_RES_HI: begin
                    end
                    default: next_st.pslverr = 1'b1;
                endcase
            end else begin
                case (paddr)
                    OFS_OPA: next_st.prdata = st.opa;
                    OFS_OPB: next_st.prdata = st.opb;
                    OFS_CTRL: begin
                        next_st.prdata[CTRL_RM_LSB +: 3] = st.round_mode;
                        next_st.prdata[CTRL_MEN_BIT] = st.mask_enable_bit;
                        next_st.prdata[CTRL_SCAL_BIT] = st.scalar_op;
                        next_st.prdata[CTRL_SRC2_LSB +: 5] = st.second_vec_source_field;
                    end
                    OFS_LEN: begin
                        next_st.prdata[LEN_VL_LSB +: 6] = st.vector_length_setting;
                        next_st.prdata[LEN_START_LSB +: 6] = st.start_index;
                    end
                    OFS_MASK: next_st.prdata = st.src_mask;
                    OFS_CMD: begin
                        next_st.prdata[CMD_OP_LSB +: 5] = st.op;
                        next_st.prdata[CMD_IDX_LSB +: 5] = st.idx;
                    end
                    OFS_RES_LO: next_st.prdata = st.res[31:0];
                    OFS_RES_HI: next_st.prdata = st.res[63:32];
                    OFS_CMASK: next_st.prdata = st.cmp_mask;
                    OFS_STAT: begin
                        next_st.prdata[STAT_FLG_LSB +: 5] = st.flags;
                        next_st.prdata[STAT_DONE_BIT] = st.done;
                        next_st.prdata[STAT_WROTE_BIT] = st.wrote;
                        next_st.prdata[STAT_ILL_BIT] = st.ill;
                    end
                    default: next_st.pslverr = 1'b1;
                endcase
            end
        end

        // Execution comes after the bus so a set beats a same-cycle clear
        if (st.go) begin
            next_st.done = 1'b1;
            next_st.wrote = 1'b0;
            if (bad) begin
                next_st.ill = 1'b1;
            end else if (st.op inside {[OP_FEQ : OP_FGE]}) begin
                // Mask lives in one register, kept apart from the source mask register
                if (active) begin
                    next_st.cmp_mask[st.idx] = cmp;
                    next_st.flags = next_st.flags | fl;
                    next_st.wrote = 1'b1;
                end else if ({1'b0, st.idx} >= st.vector_length_setting) begin
                    // Agnostic tail is filled with ones
                    next_st.cmp_mask[st.idx] = 1'b1;
                    next_st.wrote = 1'b1;
                end
            end else if (st.op == OP_MERGE) begin
                // Mask only picks the source here, never skips the element
                if (body) begin
                    next_st.res = {32'h0, r32};
                    next_st.wrote = 1'b1;
                end
            end else if (active) begin
                next_st.res = (st.op >= OP_CVT_XU) ? cvt_rsp.res : {32'h0, r32};
                next_st.flags = next_st.flags | fl;
                next_st.wrote = 1'b1;
            end
        end
    end

    // Reset loads the all-zero image, so every register reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= VFM_ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
endmodule
`default_nettype wire

// ===== sim/vfm_top_assertions.sv
// APB port checker for the vector FP datapath
`timescale 1ns/100ps
`default_nettype none
module vfm_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("stray ready");
    setup_quiet_a: assert property (psel && !penable |=> !pready) else $error("early ready");
    idle_quiet_a: assert property (!psel |=> !pready) else $error("ready while idle");
    rdata_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("rdata not zero");
    unmap_err_a: assert property (pready && paddr == 8'h28 |-> pslverr)
        else $error("unmapped without error");
    map_ok_a: assert property (pready && paddr == 8'h04 |-> !pslverr)
        else $error("mapped with error");
endmodule
bind vfm_top vfm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ===== sim/vfm_host.sv
// APB master standing in for the issuing pipeline
`timescale 1ns/100ps
`default_nettype none
module vfm_host (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Answer taken at the rising edge that sees pready high; only the bench timeout ends a wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the vector FP datapath
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import vfm_pkg::*;
    localparam logic [31:0] ONE = 32'h3f800000, TWO = 32'h40000000, NG = 32'hbf800000;
    localparam logic [31:0] QN = 32'h7fc00000, SN = 32'h7f800001, Z = 32'h0, M = '1;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    always #2 pclk = ~pclk;
    vfm_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    vfm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        h.xfer(1'b1, a, d, q, e);
    endtask
    // Flags are sticky, so status is cleared before each op
    task automatic t(input vfm_op_t o, input logic [4:0] i, input logic [31:0] a, b, c,
        input logic [7:0] ra, input logic [31:0] m, x, f);
        logic [31:0] v;
        wr(OFS_STAT, 32'h7ff);
        wr(OFS_OPA, a);
        wr(OFS_OPB, b);
        wr(OFS_CTRL, c);
        wr(OFS_CMD, {19'h0, i, 3'h0, o});
        h.xfer(1'b0, ra, Z, v, e);
        chk(v & m, x);
        h.xfer(1'b0, OFS_STAT, Z, v, e);
        chk(v & 32'h1f, f);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            h.xfer(1'b0, 8'(4 * k), Z, q, e);
            chk(q, Z);
            chk({31'h0, e}, {31'h0, k == 10});
        end
        wr(OFS_LEN, 32'h10);
        wr(OFS_MASK, 32'h1);
        t(OP_MIN, 5'h0, ONE, TWO, 32'h8, OFS_RES_LO, M, ONE, Z);
        t(OP_MAX, 5'h0, SN, TWO, 32'h8, OFS_RES_LO, M, TWO, 32'h10);
        t(OP_SGNJ, 5'h0, ONE, NG, 32'h8, OFS_RES_LO, M, NG, Z);
        t(OP_SGNJX, 5'h0, NG, NG, 32'h8, OFS_RES_LO, M, ONE, Z);
        t(OP_FNE, 5'h0, QN, ONE, 32'h8, OFS_CMASK, 32'h1, 32'h1, Z);
        t(OP_FEQ, 5'h0, SN, ONE, 32'h8, OFS_CMASK, 32'h1, Z, 32'h10);
        t(OP_FLT, 5'h0, QN, ONE, 32'h8, OFS_CMASK, 32'h1, Z, 32'h10);
        t(OP_FGT, 5'h0, TWO, ONE, 32'h18, OFS_CMASK, 32'h1, 32'h1, Z);
        t(OP_FGT, 5'h0, TWO, ONE, 32'h8, OFS_STAT, 32'h400, 32'h400, Z);
        t(OP_FEQ, 5'h14, ONE, TWO, 32'h8, OFS_CMASK, 32'h100000, 32'h100000, Z);
        t(OP_CLASS, 5'h0, ONE, Z, 32'h8, OFS_RES_LO, M, 32'h40, Z);
        t(OP_MERGE, 5'h1, ONE, TWO, Z, OFS_RES_LO, M, ONE, Z);
        t(OP_MERGE, 5'h2, ONE, TWO, 32'h8, OFS_RES_LO, M, TWO, Z);
        t(OP_CVT_X, 5'h0, 32'h3fc00000, Z, 32'ha, OFS_RES_LO, M, 32'h1, 32'h1);
        t(OP_CVT_RTZ_X, 5'h0, 32'h3fc00000, Z, 32'hb, OFS_RES_LO, M, 32'h1, 32'h1);
        t(OP_CVT_XU, 5'h0, NG, Z, 32'h8, OFS_RES_LO, M, Z, 32'h10);
        t(OP_WCVT_F_F, 5'h0, ONE, Z, 32'h8, OFS_RES_HI, M, 32'h3ff00000, Z);
        close_out();
    end
endmodule
`default_nettype wire
